// >>> rtl/lpa_params.svh
// Constants of the LP analysis front end: sizes, offsets, fixed-point
// coefficients and window oscillator seeds.
// Assumes 16-bit samples at 8 kHz; Q formats are noted per group.
`ifndef LPA_PARAMS_SVH
`define LPA_PARAMS_SVH

// ------------------------------------------------------------------
// Frame and buffer geometry (samples)
// ------------------------------------------------------------------
`define FRAME_LAST 8'h9F
`define LAST_IDX 8'hEF
`define BUF_LEN 9'h0F0
`define LAST_LAG 4'hA
`define LP_ORDER 4'hA
`define HI_MODE 3'h7
`define W1_L1 8'hA0
`define W2_L1 8'hE8
`define W3_L1 8'hC8
`define DIV_STEPS 5'h18

// ------------------------------------------------------------------
// Input high-pass, Q12; numerator already halved
// ------------------------------------------------------------------
`define HP_B0 17'h0076B
`define HP_B1 17'h00ED6
`define HP_B2 17'h0076B
`define HP_A1 17'h01E7F
`define HP_A2 17'h00E95

// ------------------------------------------------------------------
// Window oscillators, Q30; each seed is one minus cos(step)
// ------------------------------------------------------------------
`define Q30_ONE 34'h040000000
`define HAM_A 34'h0228F5C29
`define HAM_B 34'h01D70A3D7
`define DC_W1_RISE 34'h0000332BA
`define DC_W1_FALL 34'h0000CF426
`define DC_W2_RISE 34'h000018237
`define DC_W2_FALL 34'h0014F6167
`define DC_W3_RISE 34'h00002080E
`define DC_W3_FALL 34'h0000CCA7F

// ------------------------------------------------------------------
// Lag window (Q15, lag 1 in low bits), noise floor (Q20), Q24 solver
// ------------------------------------------------------------------
`define LAG_WIN_Q15 160'h728D74FE7739793_97AFC7C7F7DBF7EBA7F6F7FDC
`define WNC_Q20 23'h100069
`define A_ONE 32'h01000000
`define K_MAX 32'h00FFFFFF

`endif

// >>> rtl/lpa_pkg.sv
// Types shared by the LP analysis front end.
// Assumes lpa_params.svh supplies the numeric constants.
`default_nettype none

package lpa_pkg;

  typedef enum {
    ST_COLLECT, ST_WIN, ST_ACORR, ST_NORM,
    ST_LSUM, ST_LDIV, ST_LUPD, ST_LERR, ST_DONE
  } state_e;

  typedef logic signed [15:0] smp_t;

endpackage : lpa_pkg

`default_nettype wire

// >>> rtl/lp_analysis_front_end.sv
// LP analysis front end: input FIFO, high-pass, windowing,
// autocorrelation, lag window and order-10 recursion.
// Assumes one clock, synchronous reset, a same-clock sample source.
//
// Contract
// - Halve every input sample first
// - Second-order 80 Hz recursive high-pass
// - Halving folded into halved numerator coefficients
// - Highest-rate mode: two analyses, no lookahead
// - Lower modes: one analysis, 40-sample lookahead
// - Window one: 160 rising, 80 falling
// - Window two: 232 rising, 8 cosine
// - Both analyses share one 240-sample buffer
// - Lower modes: 200 rising, 40 cosine
// - Autocorrelation lags 0..10 over 240 samples
// - Gaussian 60 Hz lag window on 1..10
// - Zero lag scaled by 1.0001
// - Levinson recursion solves tenth order
// - Reflection, coefficient and error update steps
// - Output order-10 coefficients downstream
// - 20 ms frames, mode chosen per frame
`timescale 1ns/1ps
`default_nettype none
`include "lpa_params.svh"

// ------------------------------------------------------------------
// Sample FIFO
// ------------------------------------------------------------------
module sample_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [WIDTH-1:0] in_data_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  output logic [WIDTH-1:0] out_data_o,
  output logic out_valid_o,
  input wire logic out_ready_i
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("sample_fifo: DEPTH must be a power of two");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0] cnt_q;
  logic push, pop;

  // Handshakes straight from the fill count
  assign in_ready_o = cnt_q != (AW+1)'(DEPTH);
  assign out_valid_o = cnt_q != '0;
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  // Storage has no reset; the count alone says what is valid
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_q] <= in_data_i;
  end

  // Pointers wrap naturally on a power-of-two depth
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_q + AW'(push);
      rd_q <= rd_q + AW'(pop);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo

// ------------------------------------------------------------------
// Analysis engine
// ------------------------------------------------------------------
module lp_analysis_front_end
  import lpa_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic [15:0] sample_i,
  input wire logic sample_valid_i,
  output logic sample_ready_o,
  input wire logic [2:0] mode_i,
  output wire logic [159:0] coef_o,
  output logic coef_valid_o,
  output logic analysis_id_o
);
  localparam logic signed [16:0] B0 = `HP_B0;
  localparam logic signed [16:0] B1 = `HP_B1;
  localparam logic signed [16:0] B2 = `HP_B2;
  localparam logic signed [16:0] A1 = `HP_A1;
  localparam logic signed [16:0] A2 = `HP_A2;
  localparam logic signed [33:0] ONE = `Q30_ONE;
  localparam logic signed [33:0] HAM_A = `HAM_A;
  localparam logic signed [33:0] HAM_B = `HAM_B;
  localparam logic [159:0] LAGW = `LAG_WIN_Q15;
  localparam logic signed [22:0] WNC = `WNC_Q20;
  localparam logic signed [31:0] KMAX = `K_MAX;

  function automatic smp_t sat16(input logic signed [47:0] v);
    if (v > 48'sh7FFF)
      return 16'sh7FFF;
    else if (v < -48'sh8000)
      return -16'sh8000;
    return v[15:0];
  endfunction : sat16

  state_e state_q;
  logic [15:0] f_data;
  logic f_valid, drain, hi_q, pass_q, neg_q, sat_q;
  logic [7:0] wr_ptr_q, fill_q, new_cnt_q, n_q;
  logic [3:0] k_q, ord_q, j_q;
  logic [4:0] div_cnt_q;
  smp_t x1_q, x2_q, y1_q, y2_q, y_new, ws;
  smp_t hbuf [240];
  smp_t wbuf [240];
  logic signed [33:0] c_q, cp_q;
  logic signed [47:0] acc_q;
  logic signed [63:0] sum_q;
  logic signed [32:0] err_q;
  logic [33:0] rem_q;
  logic [24:0] q_q;
  logic signed [31:0] kr_q;
  logic signed [47:0] r_q [11];
  logic signed [31:0] a_q [11];
  logic signed [31:0] an_q [11];
  smp_t coef_q [11];

  // Source feeds the FIFO; the engine drains only while collecting
  sample_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .in_data_i(sample_i),
    .in_valid_i(sample_valid_i),
    .in_ready_o(sample_ready_o),
    .out_data_o(f_data),
    .out_valid_o(f_valid),
    .out_ready_i(state_q == ST_COLLECT)
  );
  assign drain = f_valid && state_q == ST_COLLECT;

  // ----------------------------------------------------------------
  // High-pass with the halving folded into the numerator
  // ----------------------------------------------------------------
  logic signed [36:0] hp_wide;
  assign hp_wide = $signed(f_data) * B0 - x1_q * B1 + x2_q * B2
                 + y1_q * A1 - y2_q * A2;
  assign y_new = sat16(48'(hp_wide >>> 12));

  // Filter state and ring pointers; history masked by fill count
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      {x1_q, x2_q, y1_q, y2_q} <= '0;
      wr_ptr_q <= '0;
      fill_q <= '0;
      new_cnt_q <= '0;
    end
    else if (drain)
    begin
      x1_q <= $signed(f_data);
      x2_q <= x1_q;
      y1_q <= y_new;
      y2_q <= y1_q;
      wr_ptr_q <= (wr_ptr_q == `LAST_IDX) ? '0 : wr_ptr_q + 8'h01;
      fill_q <= (fill_q == 8'(`BUF_LEN)) ? fill_q : fill_q + 8'h01;
      new_cnt_q <= (new_cnt_q == `FRAME_LAST) ? '0 : new_cnt_q + 8'h01;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (drain)
      hbuf[wr_ptr_q] <= y_new;
  end

  // ----------------------------------------------------------------
  // Window generation by cosine recurrence
  // ----------------------------------------------------------------
  logic [8:0] addr9, rd_addr;
  logic in_hist, seg2, seg_start;
  logic [7:0] l1;
  logic signed [33:0] dc, kc, c_cur, cp_cur, c_nxt, ham_t, w_q30;
  logic signed [67:0] osc_p, ham_p;
  logic signed [49:0] win_p;
  smp_t smp;

  // Oldest of the last 240 samples sits at the write pointer
  assign addr9 = {1'b0, wr_ptr_q} + {1'b0, n_q};
  assign rd_addr = (addr9 >= `BUF_LEN) ? addr9 - `BUF_LEN : addr9;
  assign in_hist = ({1'b0, n_q} + {1'b0, fill_q}) >= `BUF_LEN;
  assign smp = in_hist ? hbuf[rd_addr[7:0]] : '0;

  // Shape chosen by mode and pass
  assign l1 = !hi_q ? `W3_L1 : (pass_q ? `W2_L1 : `W1_L1);
  assign seg2 = n_q >= l1;
  assign seg_start = n_q == 8'h00 || n_q == l1;
  assign dc = !hi_q ? (seg2 ? `DC_W3_FALL : `DC_W3_RISE)
            : pass_q ? (seg2 ? `DC_W2_FALL : `DC_W2_RISE)
            : (seg2 ? `DC_W1_FALL : `DC_W1_RISE);
  assign kc = ONE - dc;

  // Each segment restarts at cos(0); drift stays small over 240 steps
  assign c_cur = seg_start ? ONE : c_q;
  assign cp_cur = seg_start ? kc : cp_q;
  assign osc_p = kc * c_cur;
  assign c_nxt = osc_p[62:29] - cp_cur;
  assign ham_p = HAM_B * c_cur;
  assign ham_t = ham_p[63:30];
  assign w_q30 = !seg2 ? HAM_A - ham_t
               : (hi_q && !pass_q) ? HAM_A + ham_t : c_cur;
  assign win_p = smp * w_q30;
  assign ws = sat16(48'($signed(win_p[49:30])));

  always_ff @(posedge sys_clk_i)
  begin
    if (state_q == ST_WIN)
      wbuf[n_q] <= ws;
  end

  // ----------------------------------------------------------------
  // Autocorrelation with lag window and noise floor
  // ----------------------------------------------------------------
  logic signed [31:0] ac_p;
  logic signed [47:0] ac_fin, r_new;
  logic signed [70:0] rs_wide;
  logic [3:0] k_m1;
  logic signed [16:0] lagw;
  logic acorr_last;

  assign ac_p = wbuf[n_q] * wbuf[8'(n_q - {4'h0, k_q})];
  assign ac_fin = acc_q + 48'(ac_p);
  assign acorr_last = n_q == `LAST_IDX;
  assign k_m1 = k_q - 4'h1;
  assign lagw = {1'b0, LAGW[{k_m1, 4'h0} +: 16]};
  assign rs_wide = (k_q == 4'h0) ? ac_fin * WNC
                 : ac_fin * lagw;
  assign r_new = (k_q == 4'h0) ? rs_wide[67:20] : rs_wide[62:15];

  // ----------------------------------------------------------------
  // Levinson-Durbin datapath, Q24 coefficients
  // ----------------------------------------------------------------
  logic norm_dn, norm_up, norm_ok, r0_zero, rem_ge;
  logic signed [63:0] ar_p, sum_fin, upd_p, kk_p;
  logic signed [39:0] num_w, mag;
  logic [33:0] rem2;
  logic signed [31:0] kmag, an_new;
  logic signed [32:0] an_sum;
  logic signed [65:0] ek_p;

  // Keep r0 in [2^30, 2^31) so the solver fits 32 bits
  assign r0_zero = r_q[0] == '0;
  assign norm_dn = |r_q[0][47:31];
  assign norm_up = !norm_dn && !r_q[0][30] && !r0_zero;
  assign norm_ok = !norm_dn && !norm_up;

  assign ar_p = a_q[j_q] * $signed(r_q[ord_q - j_q][31:0]);
  assign sum_fin = sum_q + ar_p;
  assign num_w = sum_fin[63:24];
  assign mag = num_w[39] ? -num_w : num_w;
  assign rem2 = {rem_q[32:0], 1'b0};
  assign rem_ge = rem2 >= 34'(err_q);
  assign kmag = sat_q ? KMAX : {7'h00, q_q};

  // A unit-or-larger reflection is clamped just inside one
  assign upd_p = kr_q * a_q[ord_q - j_q];
  assign an_sum = 33'(a_q[j_q]) + 33'($signed(upd_p[55:24]));
  assign an_new = (an_sum > 33'sh07FFFFFFF) ? 32'sh7FFFFFFF
                : (an_sum < -33'sh080000000) ? -32'sh80000000
                : an_sum[31:0];
  assign kk_p = kr_q * kr_q;
  assign ek_p = err_q * $signed({1'b0, kk_p[55:24]});

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      state_q <= ST_COLLECT;
      {hi_q, pass_q, neg_q, sat_q} <= '0;
      {n_q, k_q, ord_q, j_q, div_cnt_q} <= '0;
      {c_q, cp_q, acc_q, sum_q, err_q, rem_q, q_q, kr_q} <= '0;
    end
    else
    begin
      unique case (state_q)
        ST_COLLECT:
          if (drain && new_cnt_q == `FRAME_LAST)
          begin
            state_q <= ST_WIN;
            hi_q <= mode_i == `HI_MODE;
            pass_q <= 1'b0;
            n_q <= '0;
          end
        ST_WIN:
        begin
          c_q <= c_nxt;
          cp_q <= c_cur;
          n_q <= acorr_last ? '0 : n_q + 8'h01;
          acc_q <= '0;
          k_q <= '0;
          if (acorr_last)
            state_q <= ST_ACORR;
        end
        ST_ACORR:
          if (acorr_last)
          begin
            acc_q <= '0;
            k_q <= k_q + 4'h1;
            n_q <= 8'(k_q) + 8'h01;
            if (k_q == `LAST_LAG)
              state_q <= ST_NORM;
          end
          else
          begin
            acc_q <= ac_fin;
            n_q <= n_q + 8'h01;
          end
        ST_NORM:
          if (norm_ok)
          begin
            state_q <= r0_zero ? ST_DONE : ST_LSUM;
            err_q <= $signed(r_q[0][32:0]);
            ord_q <= 4'h1;
            j_q <= '0;
            sum_q <= '0;
          end
        ST_LSUM:
        begin
          sum_q <= sum_fin;
          j_q <= j_q + 4'h1;
          if (j_q == ord_q - 4'h1)
          begin
            state_q <= ST_LDIV;
            neg_q <= !num_w[39];
            sat_q <= mag >= 40'(err_q);
            rem_q <= mag[33:0];
            q_q <= '0;
            div_cnt_q <= '0;
          end
        end
        ST_LDIV:
          if (sat_q || div_cnt_q == `DIV_STEPS)
          begin
            kr_q <= neg_q ? -kmag : kmag;
            j_q <= 4'h1;
            state_q <= ST_LUPD;
          end
          else
          begin
            rem_q <= rem_ge ? rem2 - 34'(err_q) : rem2;
            q_q <= {q_q[23:0], rem_ge};
            div_cnt_q <= div_cnt_q + 5'h01;
          end
        ST_LUPD:
          if (j_q < ord_q)
            j_q <= j_q + 4'h1;
          else
            state_q <= ST_LERR;
        ST_LERR:
        begin
          err_q <= err_q - ek_p[56:24];
          j_q <= '0;
          sum_q <= '0;
          ord_q <= ord_q + 4'h1;
          state_q <= (ord_q == `LP_ORDER) ? ST_DONE : ST_LSUM;
        end
        ST_DONE:
          if (hi_q && !pass_q)
          begin
            pass_q <= 1'b1;
            n_q <= '0;
            state_q <= ST_WIN;
          end
          else
            state_q <= ST_COLLECT;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Per-lag and per-coefficient storage
  // ----------------------------------------------------------------
  for (genvar g = 0; g <= 10; g++)
  begin : g_ent
    always_ff @(posedge sys_clk_i)
    begin
      if (sys_rst_i)
        r_q[g] <= '0;
      else if (state_q == ST_ACORR && acorr_last && k_q == 4'(g))
        r_q[g] <= r_new;
      else if (state_q == ST_NORM && norm_dn)
        r_q[g] <= r_q[g] >>> 1;
      else if (state_q == ST_NORM && norm_up)
        r_q[g] <= r_q[g] <<< 1;
    end

    always_ff @(posedge sys_clk_i)
    begin
      if (sys_rst_i || (state_q == ST_NORM && norm_ok))
        a_q[g] <= (g == 0) ? `A_ONE : '0;
      else if (state_q == ST_LERR && g != 0)
        a_q[g] <= an_q[g];
    end

    always_ff @(posedge sys_clk_i)
    begin
      if (sys_rst_i || (state_q == ST_NORM && norm_ok))
        an_q[g] <= '0;
      else if (state_q == ST_LUPD && j_q < ord_q && j_q == 4'(g))
        an_q[g] <= an_new;
      else if (state_q == ST_LUPD && j_q >= ord_q && ord_q == 4'(g))
        an_q[g] <= kr_q;
    end

    // Q24 to Q12, saturated, held until the next analysis ends
    always_ff @(posedge sys_clk_i)
    begin
      if (sys_rst_i)
        coef_q[g] <= '0;
      else if (state_q == ST_DONE)
        coef_q[g] <= sat16(48'(a_q[g] >>> 12));
    end

    if (g > 0)
    begin : g_out
      assign coef_o[16*g-1 -: 16] = coef_q[g];
    end
  end

  // Completion pulse tags which window produced the set
  always_ff @(posedge sys_clk_i)
  begin
    if (sys_rst_i)
    begin
      coef_valid_o <= 1'b0;
      analysis_id_o <= 1'b0;
    end
    else
    begin
      coef_valid_o <= state_q == ST_DONE;
      if (state_q == ST_DONE)
        analysis_id_o <= pass_q;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (sys_rst_i);

  property p_valid_pulse;
    coef_valid_o |=> !coef_valid_o;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse)
    else $error("coefficient pulse longer than one cycle");

  property p_hist_clear;
    $fell(sys_rst_i) |-> fill_q == 8'h00 && y1_q == '0 && x2_q == '0;
  endproperty
  a_hist_clear: assert property (p_hist_clear)
    else $error("filter state not cleared by reset");

  property p_frame_start;
    (drain && new_cnt_q == `FRAME_LAST) |=> state_q == ST_WIN && n_q == 0;
  endproperty
  a_frame_start: assert property (p_frame_start)
    else $error("frame did not start after 160 samples");

  property p_two_pass;
    (state_q == ST_DONE && hi_q && !pass_q)
      |=> coef_valid_o && !analysis_id_o && state_q == ST_WIN;
  endproperty
  a_two_pass: assert property (p_two_pass)
    else $error("second analysis not started");

  property p_one_pass;
    (state_q == ST_DONE && !hi_q)
      |=> coef_valid_o && !analysis_id_o && state_q == ST_COLLECT;
  endproperty
  a_one_pass: assert property (p_one_pass)
    else $error("lower mode ran a second analysis");

  property p_acorr_span;
    (state_q == ST_ACORR && acorr_last && k_q != `LAST_LAG)
      |=> n_q == 8'($past(k_q)) + 8'h01 && acc_q == 0;
  endproperty
  a_acorr_span: assert property (p_acorr_span)
    else $error("next lag does not start at its own index");

  property p_norm_range;
    (state_q == ST_LSUM && ord_q == 4'h1 && j_q == 4'h0)
      |-> r_q[0][47:30] == 18'h00001;
  endproperty
  a_norm_range: assert property (p_norm_range)
    else $error("zero lag not normalised");

  property p_k_bound;
    $rose(state_q == ST_LUPD) |-> kr_q <= KMAX && kr_q >= -KMAX
      ##1 (j_q == 4'h2 || (ord_q == 4'h1 && j_q == 4'h1));
  endproperty
  a_k_bound: assert property (p_k_bound)
    else $error("reflection coefficient out of range");

  property p_order;
    (state_q == ST_LERR && ord_q == `LP_ORDER)
      |=> state_q == ST_DONE ##1 coef_valid_o;
  endproperty
  a_order: assert property (p_order)
    else $error("tenth order did not finish the analysis");

endmodule : lp_analysis_front_end
`default_nettype wire

// >>> tb/sample_src_model.sv
// Speech sample source model for the LP analysis front end.
// Assumes calls arrive just after a clock edge, one caller at a time.
`timescale 1ns/1ps
`default_nettype none

module sample_src_model (
  input wire logic sys_clk_i,
  input wire logic ready_i,
  output logic [15:0] data_o,
  output logic valid_o
);
  // Quiet line at time zero
  initial
  begin
    data_o = 16'h0000;
    valid_o = 1'b0;
  end

  // One word per strobe, held until ready is seen at an edge
  task automatic send_word(input logic [15:0] w);
    begin
      data_o = w;
      valid_o = 1'b1;
      @(posedge sys_clk_i);
      while (ready_i !== 1'b1)
        @(posedge sys_clk_i);
      #1;
    end
  endtask : send_word

  // Released line shows the inverse, so stale data never looks fresh
  task automatic go_idle();
    begin
      valid_o = 1'b0;
      data_o = ~data_o;
    end
  endtask : go_idle
endmodule : sample_src_model

`default_nettype wire

// >>> tb/test_lp_analysis_front_end.sv
// Self-checking bench for the LP analysis front end.
// Assumes the design files are compiled first; one 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none

module test_lp_analysis_front_end;
  import lpa_pkg::*;

  logic sys_clk_i;
  logic sys_rst_i;
  logic [15:0] sample_i;
  logic sample_valid_i;
  logic sample_ready_o;
  logic [2:0] mode_i;
  logic [159:0] coef_o;
  logic coef_valid_o;
  logic analysis_id_o;
  int n_fail;
  int tests_run;
  int cycles;

  lp_analysis_front_end #(.FIFO_DEPTH(16)) i_dut (
    .sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i),
    .sample_i(sample_i),
    .sample_valid_i(sample_valid_i),
    .sample_ready_o(sample_ready_o),
    .mode_i(mode_i),
    .coef_o(coef_o),
    .coef_valid_o(coef_valid_o),
    .analysis_id_o(analysis_id_o)
  );

  sample_src_model i_src (
    .sys_clk_i(sys_clk_i),
    .ready_i(sample_ready_o),
    .data_o(sample_i),
    .valid_o(sample_valid_i)
  );

  // ------------------------------------------------------------------
  // Clock, run limit and shared checks
  // ------------------------------------------------------------------
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  // Ceiling sized for nine silent frames plus one voiced frame
  always @(posedge sys_clk_i)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      n_fail++;
      complete_run();
    end
  end

  task automatic check(input logic [159:0] seen, input logic [159:0] exp);
    begin
      tests_run++;
      if (seen !== exp)
      begin
        n_fail++;
        $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen,
          exp);
      end
    end
  endtask : check

  task automatic complete_run();
    begin
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask : complete_run

  // Bounded wait for the one-cycle done pulse, looked at in its cycle
  task automatic wait_pulse(input int lim, output bit got);
    begin
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++)
      begin
        @(posedge sys_clk_i);
        #1;
        if (coef_valid_o === 1'b1)
          got = 1'b1;
      end
    end
  endtask : wait_pulse

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  // Outputs right after reset
  task automatic reset_state();
    begin
      check(coef_o, 160'h0);
      check(coef_valid_o, 1'b0);
      check(analysis_id_o, 1'b0);
      check(sample_ready_o, 1'b1);
    end
  endtask : reset_state

  // Reset held three cycles, cleared outputs checked before release
  task automatic pulse_reset();
    begin
      sys_rst_i = 1'b1;
      repeat (3) @(posedge sys_clk_i);
      #1;
      reset_state();
      sys_rst_i = 1'b0;
    end
  endtask : pulse_reset

  // Silent frame: zero coefficients, pulse count set by the mode
  task automatic silent_frame(input logic [2:0] m);
    bit got;
    begin
      mode_i = m;
      for (int i = 0; i < 160; i++)
        i_src.send_word(16'h0000);
      i_src.go_idle();
      wait_pulse(8000, got);
      check(got, 1'b1);
      check(analysis_id_o, 1'b0);
      check(coef_o, 160'h0);
      wait_pulse(4000, got);
      check(got, m == 3'h7);
      if (got)
      begin
        check(analysis_id_o, 1'b1);
        check(coef_o, 160'h0);
        wait_pulse(4000, got);
        check(got, 1'b0);
      end
    end
  endtask : silent_frame

  // Nyquist-rate tone, then a full FIFO while the engine is busy
  task automatic tone_and_fill();
    bit got;
    logic [159:0] held;
    begin
      mode_i = 3'h0;
      for (int i = 0; i < 160; i++)
        i_src.send_word(i[0] ? 16'hE0C0 : 16'h1F40);
      // Engine is busy now, so sixteen more words fill the FIFO
      for (int i = 0; i < 16; i++)
        i_src.send_word(16'h0000);
      i_src.go_idle();
      check(sample_ready_o, 1'b0);
      wait_pulse(8000, got);
      check(got, 1'b1);
      // Alternating input gives a large positive first tap
      held = coef_o;
      check($signed(coef_o[15:0]) > 16'sh0800, 1'b1);
      check(coef_o[15:0] !== 16'h1000, 1'b1);
      repeat (30) @(posedge sys_clk_i);
      #1;
      check(coef_o, held);
      check(sample_ready_o, 1'b1);
    end
  endtask : tone_and_fill

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial
  begin
    n_fail = 0;
    tests_run = 0;
    cycles = 0;
    mode_i = 3'h0;
    pulse_reset();
    for (int m = 0; m < 8; m++)
      silent_frame(m[2:0]);
    tone_and_fill();
    // Stale tone history and filter state must not leak past a reset
    pulse_reset();
    silent_frame(3'h2);
    complete_run();
  end
endmodule : test_lp_analysis_front_end

`default_nettype wire
